// File: rtl/tbs_supervisor.v
// What this block does
// - Host switches channels, sets level, reads status
// - Channel 2 level from 7-bit code
// - New code acts only on commit
// - Divider sets level until code committed
// - Grounded or floating bus lines disable bus
// - Bus-less: enable pins and divider only
// - Continuous conduction unless pulse-skip enabled
// - Channel 1 clock opposite channels 2 and 3
// - Align cycles to external clock falling edge
// - Overcurrent past 256 cycles: hiccup 8192
// - Overvoltage holds high side off until below 105%
// - Power-ok high when all good, sequence done
// - Power-good comparators readable over bus
// - Over-temperature shuts down, restarts soft
// - Low bootstrap forces switch node low
// - Falling power-good deglitched 112 cycles
// - Rising power-good deglitched 616 cycles
`timescale 1ns/1ps
`default_nettype none
`include "tbs_regs.vh"
module tbs_supervisor (
  input wire clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_oe_q,
  input wire sw_clk,
  input wire ext_sync,
  input wire [2:0] channel_enable_pin,
  input wire [2:0] over_current,
  input wire [2:0] over_volt,
  input wire [2:0] fb_below_105,
  input wire [2:0] boot_low,
  input wire [2:0] pg_comp,
  input wire over_temp,
  input wire seq_done,
  output reg [2:0] chan_run_q,
  output reg [2:0] hs_block_q,
  output reg [2:0] switch_node_low_q,
  output reg [2:0] pulse_skip_operation_q,
  output reg [2:0] phase_clk_q,
  output reg ch2_use_internal_q,
  output reg [6:0] output_level_code_q,
  output reg restart_soft_q,
  output reg bus_mode_q,
  output reg power_ok_output_q
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_ADDR = 4'b0010;
  localparam ST_DATA = 4'b0100;
  localparam ST_IGN = 4'b1000;

  // Two-stage synchronisers for bus, clock, sync and over-temperature pins
  reg [4:0] s1_q;
  reg [4:0] s2_q;
  reg [4:0] s3_q;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Reset low: a bus is only taken as present once its pins are seen high
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
    end
    else
    begin
      s1_q <= {over_temp, ext_sync, sw_clk, sda_in, scl_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  wire scl = s2_q[0];
  wire sda = s2_q[1];
  wire scl_rise = scl && !s3_q[0];
  wire scl_fall = !scl && s3_q[0];
  wire start_c = scl && s3_q[0] && !sda && s3_q[1];
  wire stop_c = scl && s3_q[0] && sda && !s3_q[1];
  wire ext_fall = !s2_q[3] && s3_q[3];
  wire sw_rise = s2_q[2] && !s3_q[2];
  wire hot = s2_q[4];

  // Bus presence: both lines once seen high together enable the bus
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus_mode_q <= 1'b0;
    else if (scl && sda)
      bus_mode_q <= 1'b1;
  end

  // Switching tick: external sync falling edge overrides internal clock
  reg sync_seen_q;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_seen_q <= 1'b0;
    else if (ext_fall)
      sync_seen_q <= 1'b1;
  end
  // The first falling edge of the external clock already counts as a cycle
  wire sw_tick = ext_fall || (!sync_seen_q && sw_rise);

  reg ph_q;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_q <= 1'b0;
      phase_clk_q <= 3'h0;
    end
    else
    begin
      if (sw_tick)
        ph_q <= !ph_q;
      phase_clk_q <= {ph_q, ph_q, !ph_q};
    end
  end

  // Registers
  reg [6:0] code_q;
  reg [2:0] bus_en_q;
  reg [2:0] skip_q;
  reg [7:0] radr_q;
  reg [7:0] sh_q;
  reg [3:0] bit_q;
  reg [3:0] st_q;
  reg rw_q;
  reg ack_q;
  reg [7:0] rdata;
  always @*
  begin
    rdata = 8'h00;
    if (radr_q == `TBS_REG_CODE)
      rdata = {1'b0, code_q};
    else if (radr_q == `TBS_REG_CMD)
      rdata = {5'h00, pg_comp};
    else if (radr_q == `TBS_REG_ENA)
      rdata = {5'h00, bus_en_q};
    else if (radr_q == `TBS_REG_SKIP)
      rdata = {5'h00, skip_q};
    else if (radr_q == `TBS_REG_STAT)
      rdata = {4'h0, hot, pg_comp};
  end

  // Byte-wide target: bit_q counts 0..7 data, 8 is acknowledge
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      radr_q <= 8'h00;
      code_q <= 7'h00;
      bus_en_q <= 3'h7;
      skip_q <= 3'h0;
      output_level_code_q <= 7'h00;
      ch2_use_internal_q <= 1'b0;
    end
    else if (!bus_mode_q || start_c)
    begin
      // Bus-less mode holds the target in reset
      st_q <= bus_mode_q ? ST_ADDR : ST_IDLE;
      bit_q <= 4'h0;
      sda_oe_q <= 1'b0;
      ack_q <= 1'b0;
    end
    else if (stop_c)
    begin
      st_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end
    else if (scl_rise && bit_q < 4'h8 && st_q != ST_IDLE)
    begin
      sh_q <= {sh_q[6:0], sda};
      bit_q <= bit_q + 4'h1;
    end
    else if (scl_rise && bit_q == 4'h8 && rw_q && st_q == ST_DATA && sda)
      st_q <= ST_IGN; // Master NACK ends the read
    else if (scl_fall && st_q != ST_IDLE && st_q != ST_IGN)
    begin
      if (bit_q == 4'h8 && !ack_q)
      begin
        ack_q <= 1'b1;
        if (st_q == ST_ADDR)
        begin
          if (sh_q[7:1] == `TBS_DEV_ADDR)
          begin
            rw_q <= sh_q[0];
            sda_oe_q <= 1'b1;
            if (sh_q[0])
              sh_q <= rdata;
          end
          else
            st_q <= ST_IGN;
        end
        else if (!rw_q)
        begin
          sda_oe_q <= 1'b1;
          if (bit_q == 4'h8 && radr_q == 8'hFF)
            radr_q <= sh_q;
          else
          begin
            if (radr_q == `TBS_REG_CODE)
              code_q <= sh_q[6:0];
            else if (radr_q == `TBS_REG_CMD && sh_q[`TBS_CMD_COMMIT])
            begin
              output_level_code_q <= code_q;
              ch2_use_internal_q <= 1'b1;
            end
            else if (radr_q == `TBS_REG_ENA)
              bus_en_q <= sh_q[2:0];
            else if (radr_q == `TBS_REG_SKIP)
              skip_q <= sh_q[2:0];
            radr_q <= radr_q + 8'h01;
          end
        end
        else
        begin
          // Release for the host's acknowledge; step so the next byte loads fresh data
          sda_oe_q <= 1'b0;
          radr_q <= radr_q + 8'h01;
        end
      end
      else if (bit_q == 4'h8)
      begin
        // Leaving acknowledge slot
        ack_q <= 1'b0;
        bit_q <= 4'h0;
        if (st_q == ST_ADDR)
        begin
          st_q <= ST_DATA;
          if (!rw_q)
            radr_q <= 8'hFF;
        end
        if (st_q == ST_DATA && rw_q)
          sh_q <= rdata;
        sda_oe_q <= rw_q && (st_q == ST_ADDR ? !sh_q[7] : !rdata[7]);
      end
      else if (rw_q && st_q == ST_DATA)
      begin
        // Each rising edge shifts, so the next bit to send sits on top
        sda_oe_q <= !sh_q[7];
      end
    end
  end

  // Over-temperature: stop all channels, restart through soft-start
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      restart_soft_q <= 1'b0;
    else
      restart_soft_q <= hot;
  end
  wire [2:0] ch_on = (bus_mode_q ? (bus_en_q & channel_enable_pin) : channel_enable_pin)
                     & {3{!hot}};

  wire [2:0] run_w;
  wire [2:0] hsb_w;
  wire [2:0] swl_w;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_ch
      tbs_chan_guard u_guard (
        .clk(clk),
        .rst_n(rst_n),
        .sw_tick(sw_tick),
        .chan_on(ch_on[g]),
        .over_current(over_current[g]),
        .over_volt(over_volt[g]),
        .fb_below_105(fb_below_105[g]),
        .boot_low(boot_low[g]),
        .run_q(run_w[g]),
        .hs_block_q(hsb_w[g]),
        .sw_low_q(swl_w[g]),
        .oc_warn_q()
      );
    end
  endgenerate

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_run_q <= 3'h0;
      hs_block_q <= 3'h0;
      switch_node_low_q <= 3'h0;
      pulse_skip_operation_q <= 3'h0;
    end
    else
    begin
      chan_run_q <= run_w;
      hs_block_q <= hsb_w;
      switch_node_low_q <= swl_w;
      pulse_skip_operation_q <= bus_mode_q ? skip_q : 3'h0;
    end
  end

  // Power-ok deglitch in switching cycles
  localparam [9:0] PG_FALL_END = `TBS_PG_FALL - 1;
  localparam [9:0] PG_RISE_END = `TBS_PG_RISE - 1;
  reg [9:0] pg_cnt_q;
  wire pg_raw = (&pg_comp) && seq_done && !hot;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pg_cnt_q <= 10'h000;
      power_ok_output_q <= 1'b0;
    end
    else if (pg_raw == power_ok_output_q)
      pg_cnt_q <= 10'h000;
    else if (sw_tick)
    begin
      if (!pg_raw && pg_cnt_q == PG_FALL_END)
      begin
        power_ok_output_q <= 1'b0;
        pg_cnt_q <= 10'h000;
      end
      else if (pg_raw && pg_cnt_q == PG_RISE_END)
      begin
        power_ok_output_q <= 1'b1;
        pg_cnt_q <= 10'h000;
      end
      else
        pg_cnt_q <= pg_cnt_q + 10'h001;
    end
  end
endmodule // tbs_supervisor
`default_nettype wire

// File: rtl/tbs_regs.vh
`ifndef TBS_REGS_VH
`define TBS_REGS_VH
// Device address on the two-wire bus (7 bit)
`define TBS_DEV_ADDR 7'h60
// Register indices
`define TBS_REG_CODE 8'h00
`define TBS_REG_CMD 8'h01
`define TBS_REG_ENA 8'h02
`define TBS_REG_SKIP 8'h03
`define TBS_REG_STAT 8'h04
// Command register fields
`define TBS_CMD_COMMIT 0
// Output level code: 0.68 V base, 10 mV step, 7 bits
`define TBS_CODE_W 7
`define TBS_CODE_BASE_MV 680
`define TBS_CODE_STEP_MV 10
// Fault timing in switching cycles
`define TBS_OC_WAIT 256
`define TBS_HICCUP 8192
`define TBS_PG_FALL 112
`define TBS_PG_RISE 616
`endif

// File: rtl/tbs_chan_guard.v
`timescale 1ns/1ps
`default_nettype none
`include "tbs_regs.vh"
// Per-channel overcurrent hiccup, overvoltage gate and bootstrap refresh
module tbs_chan_guard #(
  parameter HICCUP_CYC = `TBS_HICCUP
) (
  input wire clk,
  input wire rst_n,
  input wire sw_tick,
  input wire chan_on,
  input wire over_current,
  input wire over_volt,
  input wire fb_below_105,
  input wire boot_low,
  output reg run_q,
  output reg hs_block_q,
  output reg sw_low_q,
  output reg oc_warn_q
);
  reg [8:0] oc_cnt_q;
  reg [13:0] hic_cnt_q;
  reg hic_q;
  reg ov_hold_q;
  localparam [13:0] HIC_END = HICCUP_CYC - 1;
  localparam [8:0] OC_END = `TBS_OC_WAIT;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oc_cnt_q <= 9'h000;
      hic_cnt_q <= 14'h0000;
      hic_q <= 1'b0;
      ov_hold_q <= 1'b0;
      run_q <= 1'b0;
      hs_block_q <= 1'b0;
      sw_low_q <= 1'b0;
      oc_warn_q <= 1'b0;
    end
    else
    begin
      if (hic_q)
      begin
        oc_cnt_q <= 9'h000;
        if (sw_tick)
        begin
          if (hic_cnt_q == HIC_END)
          begin
            hic_q <= 1'b0;
            hic_cnt_q <= 14'h0000;
          end
          else
            hic_cnt_q <= hic_cnt_q + 14'h0001;
        end
      end
      else if (!over_current || !chan_on)
        oc_cnt_q <= 9'h000;
      else if (sw_tick)
      begin
        // More than the wait time: trip on the cycle after the count fills
        if (oc_cnt_q == OC_END)
          hic_q <= 1'b1;
        else
          oc_cnt_q <= oc_cnt_q + 9'h001;
      end
      if (over_volt)
        ov_hold_q <= 1'b1;
      else if (fb_below_105)
        ov_hold_q <= 1'b0;
      oc_warn_q <= over_current;
      run_q <= chan_on && !hic_q;
      hs_block_q <= ov_hold_q || over_volt || boot_low;
      sw_low_q <= boot_low && chan_on && !hic_q;
    end
  end
endmodule // tbs_chan_guard
`default_nettype wire

// File: test/tbs_supervisor_props.sv
`timescale 1ns/1ps
`default_nettype none
module tbs_supervisor_props (
  input wire clk,
  input wire rst_n,
  input wire sw_clk,
  input wire [2:0] channel_enable_pin,
  input wire [2:0] over_current,
  input wire [2:0] over_volt,
  input wire [2:0] fb_below_105,
  input wire [2:0] pg_comp,
  input wire over_temp,
  input wire seq_done,
  input wire [2:0] chan_run_q,
  input wire [2:0] hs_block_q,
  input wire [2:0] phase_clk_q,
  input wire ch2_use_internal_q,
  input wire [6:0] output_level_code_q,
  input wire restart_soft_q,
  input wire power_ok_output_q
);
  logic sw_q;
  logic [15:0] hi_q, lo_q, oc_q;
  wire tick = sw_clk & ~sw_q;
  wire raw = &pg_comp & seq_done & ~over_temp;
  // Counts may trail the block by a tick, so bounds keep a small margin
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_q <= 1'b0;
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
      oc_q <= 16'h0000;
    end
    else
    begin
      sw_q <= sw_clk;
      hi_q <= raw ? hi_q + {15'h0000, tick} : 16'h0000;
      lo_q <= raw ? 16'h0000 : lo_q + {15'h0000, tick};
      oc_q <= over_current[0] ? oc_q + {15'h0000, tick} : 16'h0000;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_ov;
    (over_volt[1] && !fb_below_105[1]) [*3];
  endsequence
  property p_phase;
    $past(rst_n) |-> phase_clk_q[1] == phase_clk_q[2] && phase_clk_q[0] != phase_clk_q[1];
  endproperty
  property p_pin; (chan_run_q & ~$past(channel_enable_pin, 2)) == 3'h0; endproperty
  property p_commit; $changed(output_level_code_q) |-> ch2_use_internal_q; endproperty
  property p_rise; $rose(power_ok_output_q) |-> hi_q >= 16'h0266; endproperty
  property p_rise_by; hi_q >= 16'h026B |-> power_ok_output_q; endproperty
  property p_fall; $fell(power_ok_output_q) |-> lo_q >= 16'h006E; endproperty
  property p_oc; $fell(chan_run_q[0]) && over_current[0] |-> oc_q >= 16'h00FF; endproperty
  property p_ovp; s_ov |-> hs_block_q[1]; endproperty
  property p_temp; restart_soft_q && $past(restart_soft_q) |-> chan_run_q == 3'h0; endproperty
  a_phase: assert property (p_phase) else $error("phase pair split");
  a_pin: assert property (p_pin) else $error("run without pin");
  a_commit: assert property (p_commit) else $error("code moved early");
  a_rise: assert property (p_rise) else $error("power ok rose early");
  a_rise_by: assert property (p_rise_by) else $error("power ok late");
  a_fall: assert property (p_fall) else $error("power ok fell early");
  a_oc: assert property (p_oc) else $error("overcurrent trip early");
  a_ovp: assert property (p_ovp) else $error("high side not held");
  a_temp: assert property (p_temp) else $error("run while hot");
endmodule // tbs_supervisor_props
`default_nettype wire

// File: test/tbs_i2c_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbs_regs.vh"
module tbs_i2c_host (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl_q,
  output logic sda_q
);
  int nacks = 0;
  initial
  begin
    scl_q = 1'b0;
    sda_q = 1'b0;
  end
  task automatic pin(input logic c, input logic d);
    scl_q <= c;
    sda_q <= d;
    // One fixed phase length: the host never speeds the bus clock up
    repeat (10) @(posedge clk);
  endtask
  // SDA only moves while SCL is low, so no false START or STOP
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
    begin
      pin(1'b0, sda_q);
      pin(1'b0, d[i]);
      pin(1'b1, d[i]);
      q[i] = sda_line;
      pin(1'b1, d[i]);
    end
  endtask
  task automatic wb(input logic [7:0] b);
    logic [8:0] q;
    xfer({b, 1'b1}, q);
    nacks += q[0];
  endtask
  task automatic start;
    pin(1'b1, 1'b1);
    pin(1'b1, 1'b0);
  endtask
  task automatic stop;
    pin(1'b0, sda_q);
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    start();
    wb({`TBS_DEV_ADDR, 1'b0});
    wb(idx);
    wb(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    logic [8:0] q;
    start();
    wb({`TBS_DEV_ADDR, 1'b0});
    wb(idx);
    stop();
    start();
    wb({`TBS_DEV_ADDR, 1'b1});
    xfer(9'h1FF, q);
    stop();
    d = q[8:1];
  endtask
endmodule // tbs_i2c_host
`default_nettype wire

// File: test/test_tbs_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbs_regs.vh"
module test_tbs_supervisor;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sw_clk = 1'b0;
  logic ext_sync = 1'b0;
  logic over_temp = 1'b0;
  logic seq_done = 1'b0;
  logic [2:0] sw_cnt = 3'h0;
  logic [2:0] channel_enable_pin = 3'h7;
  logic [2:0] over_current = 3'h0, over_volt = 3'h0, fb_below_105 = 3'h0;
  logic [2:0] boot_low = 3'h0, pg_comp = 3'h0;
  logic [2:0] chan_run_q, hs_block_q, switch_node_low_q, pulse_skip_operation_q, phase_clk_q;
  logic [6:0] output_level_code_q;
  logic ch2_use_internal_q, restart_soft_q, bus_mode_q, power_ok_output_q, sda_oe_q;
  logic scl_in, sda_in, host_sda;
  logic [7:0] prev = 8'h00;
  logic [2:0] ph_seen;
  logic [6:0] codes [3] = '{7'h2A, 7'h00, 7'h7F};
  int errors = 0;
  int tests_run = 0;
  assign sda_in = host_sda & ~sda_oe_q;
  always #2 clk = ~clk;
  // One tick every 8 clocks keeps the long deglitch runs short
  always @(posedge clk)
  begin
    sw_cnt <= sw_cnt + 3'h1;
    sw_clk <= sw_cnt[2];
  end
  tbs_supervisor dut (.*);
  tbs_i2c_host host (.clk(clk), .sda_line(sda_in), .scl_q(scl_in), .sda_q(host_sda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(idx, d);
    chk(d, exp);
  endtask
  task automatic tk(input int n);
    repeat (n * 8) @(posedge clk);
  endtask
  task automatic finish_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #400_000;
    errors++;
    finish_test();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    channel_enable_pin <= 3'h5;
    tk(4);
    chk(chan_run_q, 8'h05);
    chk({ch2_use_internal_q, bus_mode_q}, 8'h00);
    channel_enable_pin <= 3'h7;
    rdc(`TBS_REG_ENA, 8'h07);
    rdc(`TBS_REG_SKIP, 8'h00);
    chk(bus_mode_q, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      host.wr(`TBS_REG_CODE, {1'b0, codes[i]});
      chk({ch2_use_internal_q, output_level_code_q}, prev);
      rdc(`TBS_REG_CODE, {1'b0, codes[i]});
      host.wr(`TBS_REG_CMD, 8'h01);
      prev = {1'b1, codes[i]};
      chk({ch2_use_internal_q, output_level_code_q}, prev);
    end
    host.wr(`TBS_REG_SKIP, 8'h05);
    chk(pulse_skip_operation_q, 8'h05);
    host.wr(`TBS_REG_ENA, 8'h02);
    chk(chan_run_q, 8'h02);
    host.wr(`TBS_REG_ENA, 8'h07);
    pg_comp <= 3'h3;
    rdc(`TBS_REG_CMD, 8'h03);
    rdc(`TBS_REG_STAT, 8'h03);
    rdc(8'h05, 8'h00);
    seq_done <= 1'b1;
    pg_comp <= 3'h7;
    tk(605);
    chk(power_ok_output_q, 8'h00);
    tk(20);
    chk(power_ok_output_q, 8'h01);
    pg_comp <= 3'h6;
    tk(105);
    chk(power_ok_output_q, 8'h01);
    tk(15);
    chk(power_ok_output_q, 8'h00);
    over_current <= 3'h1;
    tk(250);
    chk(chan_run_q, 8'h07);
    tk(12);
    chk(chan_run_q, 8'h06);
    over_current <= 3'h0;
    over_temp <= 1'b1;
    tk(2);
    chk({restart_soft_q, chan_run_q}, 8'h08);
    over_temp <= 1'b0;
    tk(2);
    chk(restart_soft_q, 8'h00);
    over_volt <= 3'h2;
    tk(1);
    over_volt <= 3'h0;
    tk(1);
    chk(hs_block_q, 8'h02);
    fb_below_105 <= 3'h2;
    boot_low <= 3'h4;
    tk(2);
    // Switch node forced low also keeps the high side off
    chk({hs_block_q, switch_node_low_q}, 8'h24);
    // Once the external clock is seen, cycles follow only its falling edges
    ext_sync <= 1'b1;
    tk(1);
    ext_sync <= 1'b0;
    tk(1);
    ph_seen = phase_clk_q;
    chk({phase_clk_q[0] ^ phase_clk_q[1], phase_clk_q[1] ^ phase_clk_q[2]}, 8'h02);
    tk(4);
    chk({5'h00, phase_clk_q}, {5'h00, ph_seen});
    ext_sync <= 1'b1;
    tk(1);
    ext_sync <= 1'b0;
    tk(1);
    chk({5'h00, phase_clk_q}, {5'h00, ~ph_seen});
    chk(8'(host.nacks), 8'h00);
    finish_test();
  end
endmodule // test_tbs_supervisor
bind tbs_supervisor tbs_supervisor_props u_props (.*);
`default_nettype wire
